// File: hdl/etx_pkg.sv
// Shared constants and types for the E1 transmit system interface
package etx_pkg;
	// ==========
	// Clocks and rates
	localparam int MCLK_HZ = 250_000_000;
	localparam int BIT_HZ = 2_048_000;
	localparam int MUX_BIT_HZ = 8_192_000;
	// Half periods of generated clocks, in mclk cycles
	localparam int LTC_HALF = MCLK_HZ / (2 * BIT_HZ);
	localparam int BP_HALF = MCLK_HZ / (2 * BIT_HZ);
	localparam int BP_DBL_HALF = MCLK_HZ / (4 * BIT_HZ);
	localparam int MUX_HALF = MCLK_HZ / (2 * MUX_BIT_HZ);
	localparam int MUX_DBL_HALF = MCLK_HZ / (4 * MUX_BIT_HZ);
	// ==========
	// Frame layout
	localparam logic [9:0] FRAME_BITS_LAST = 10'h0ff;
	localparam logic [9:0] MUX_FRAME_BITS_LAST = 10'h3ff;
	localparam logic [4:0] SIG_SLOT = 5'h10;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// ==========
	// Modes
	typedef enum logic [2:0] {
		MODE_SLAVE_SIG = 3'b001,
		MODE_MASTER = 3'b010,
		MODE_MUX = 3'b100
	} etx_mode_t;
	// ==========
	// Controller registers (AXI4-Lite byte addresses)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_PATTERN = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [31:0] CTRL_RESET = 32'h00000011;
	localparam logic [31:0] PATTERN_RESET = 32'h0000f0a5;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SPEED = 3;
	localparam int CTRL_LAUNCH_RISE = 4;
	localparam int CTRL_INVERT = 5;
	localparam int CTRL_MF_TYPE = 6;
	localparam int CTRL_BUS = 7;
	localparam int CTRL_ENABLE = 8;
	localparam logic [3:0] MF_LAST = 4'hf;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hdl/etx_link_if.sv
// Backplane link between system logic and one framer transmit channel
interface etx_link_if;
	logic backplaneClk;
	logic framePulse;
	logic serialData;
	logic lineTxClk;
	logic muxClk;
	logic muxFramePulse;
	logic [1:0] muxData;
	logic [1:0] muxSig;
	// Shared frame-sync / signalling pin
	logic pinDevOut;
	logic pinDevOe;
	logic pinHostOut;
	logic pinHostOe;
	logic pinLevel;
	assign pinLevel = pinDevOe ? pinDevOut : (pinHostOe ? pinHostOut : 1'b0);
	modport dev(
		input backplaneClk, framePulse, serialData, muxClk, muxFramePulse,
		input muxData, muxSig, pinLevel,
		output lineTxClk, pinDevOut, pinDevOe
	);
	modport host(
		output backplaneClk, framePulse, serialData, muxClk, muxFramePulse,
		output muxData, muxSig, pinHostOut, pinHostOe,
		input lineTxClk, pinLevel
	);
endinterface

// File: hdl/etx_framer_tx.sv
// Framer-side transmit system interface for one E1 channel
// Functional notes
// RULE1: Slave: frame pulse on FE, data on DE.
// RULE2: Differing edges: frame edge precedes data edge.
// RULE3: Each slot serialised most significant first.
// RULE4: Slave signalling mode: shared pin is input.
// RULE5: TS16 signalling only without COMMON_CHANNEL_SIGNALING, source zero.
// RULE6: Master: drive frame sync each frame start.
// RULE7: Master data rate 2.048 Mb/s.
// RULE8: Master: own line clock, DE and FS edges.
// RULE9: Mux: bus select picks one of two.
// RULE10: Sharing framers need distinct slot offsets.
// RULE11: Mux: frame pulse on FE, data on DE.
// RULE12: Speed bit: single or double rate clock.
// RULE13: Double rate: offset picks edge; pulse first.
// RULE14: Mux: any framer's speed/offset one forces all.
// RULE15: Mux pulse once per frame, polarity programmable.
// RULE16: Mux data rate 8.192 Mb/s.
// RULE17: Mux signalling slot-aligned with mux data.
// RULE18: All framers share edge and polarity settings.
// RULE19: Slave pulse per frame or multiframe.
// RULE20: Slave clock 2.048 or 4.096 MHz.
// RULE21: Non-mux framer ignores both mux buses.
module etx_framer_tx
	import etx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	etx_link_if.dev link,
	input wire etx_mode_t mode,
	input wire logic frameEdgeSelect,
	input wire logic dataEdgeSelect,
	input wire logic frameSyncEdgeBit,
	input wire logic clockSpeedSelect,
	input wire logic clockEdgeOffset,
	input wire logic [6:0] peerClockSpeed,
	input wire logic [6:0] peerClockOffset,
	input wire logic muxBusChoice,
	input wire logic [6:0] timeslotOffset,
	input wire logic framePulseInvert,
	input wire logic framePulseType,
	input wire logic commonChannelSignaling,
	input wire logic signalingSourceBit,
	output logic [7:0] txByte,
	output logic [4:0] txSlot,
	output logic txValid,
	output logic txSigUsed,
	output logic [3:0] txFrame
);
	// ==========
	// Input synchronisers
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] syncA;
	logic [NSYNC-1:0] syncB;
	assign raw = {link.muxSig, link.muxData, link.muxFramePulse, link.muxClk,
		link.pinLevel, link.serialData, link.framePulse, link.backplaneClk};
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			syncA <= '0;
			syncB <= '0;
		end else begin
			syncA <= raw;
			syncB <= syncA;
		end
	end
	wire bpClkS = syncB[0];
	wire fpS = syncB[1];
	wire sdS = syncB[2];
	wire pinS = syncB[3];
	wire muxClkS = syncB[4];
	wire muxFpS = syncB[5];
	wire [1:0] muxDataS = syncB[7:6];
	wire [1:0] muxSigS = syncB[9:8];

	// ==========
	// Line transmit clock divider
	logic [6:0] ltcCnt;
	logic lineClk;
	wire ltcWrap = (ltcCnt == 7'(LTC_HALF - 1));
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ltcCnt <= '0;
			lineClk <= 1'b0;
		end else begin
			ltcCnt <= ltcWrap ? 7'h00 : ltcCnt + 7'h01;
			lineClk <= lineClk ^ ltcWrap; // [RULE7] [RULE8]
		end
	end

	// ==========
	// Mode decode and clock selection
	wire isMaster = (mode == MODE_MASTER);
	wire isMux = (mode == MODE_MUX);
	wire isSig = (mode == MODE_SLAVE_SIG);
	wire clkNow = isMaster ? lineClk : (isMux ? muxClkS : bpClkS); // [RULE8]
	logic clkPrev;
	wire rise = clkNow & ~clkPrev;
	wire fall = ~clkNow & clkPrev;
	wire feEdge = frameEdgeSelect ? rise : fall; // [RULE1] [RULE11]
	wire deEdge = dataEdgeSelect ? rise : fall; // [RULE1] [RULE8] [RULE11]
	wire fsEdge = frameSyncEdgeBit ? rise : fall; // [RULE8]
	// Any framer's one wins on the shared mux clock
	wire effSpeed = ~isMaster & (clockSpeedSelect | (isMux & |peerClockSpeed)); // [RULE12] [RULE14] [RULE20]
	wire effOffset = clockEdgeOffset | (isMux & |peerClockOffset); // [RULE14]

	// ==========
	// Data, signalling and pulse selection
	wire dIn = isMux ? muxDataS[muxBusChoice] : sdS; // [RULE9] [RULE21]
	wire sIn = isMux ? muxSigS[muxBusChoice] : pinS; // [RULE4] [RULE17] [RULE21]
	wire fpRaw = isMux ? muxFpS : fpS; // [RULE21]
	wire fpActive = ~isMaster & (fpRaw ^ framePulseInvert); // [RULE15] [RULE19]

	// ==========
	// Frame alignment
	logic fpSeenPrev;
	logic pending;
	logic dePhase;
	logic [9:0] bitIndex;
	logic [3:0] frameNum;
	// Only the first edge that sees the pulse counts
	wire fpAccept = feEdge & fpActive & ~fpSeenPrev; // [RULE13]
	// Pulse taken on FE lines up with the next DE edge
	wire frameStart = deEdge & (pending | fpAccept); // [RULE2]
	wire curPhase = frameStart ? 1'b0 : dePhase;
	wire take = deEdge & (~effSpeed | (curPhase == effOffset)); // [RULE13]
	wire [9:0] bitNum = frameStart ? 10'h000 : bitIndex;
	wire [9:0] lastBit = isMux ? MUX_FRAME_BITS_LAST : FRAME_BITS_LAST; // [RULE16]
	wire [9:0] bitNext = (bitNum == lastBit) ? 10'h000 : bitNum + 10'h001;
	wire wrap = take & (bitNum == lastBit);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			clkPrev <= 1'b0;
			fpSeenPrev <= 1'b0;
			pending <= 1'b0;
			dePhase <= 1'b0;
		end else begin
			clkPrev <= clkNow;
			if (feEdge)
				fpSeenPrev <= fpActive;
			if (deEdge)
				pending <= 1'b0;
			else if (fpAccept)
				pending <= 1'b1; // [RULE2]
			if (deEdge)
				dePhase <= effSpeed & ~curPhase;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bitIndex <= '0;
			frameNum <= '0;
		end else begin
			if (frameStart & ~take)
				bitIndex <= 10'h000;
			else if (take)
				bitIndex <= bitNext;
			if (frameStart & framePulseType & ~isMux)
				frameNum <= 4'h0; // [RULE19]
			else if (wrap)
				frameNum <= frameNum + 4'h1;
		end
	end

	// ==========
	// Slot ownership and byte assembly
	wire [6:0] slotRaw = bitNum[9:3];
	wire [6:0] slotLocal = slotRaw - (isMaster ? 7'h00 : timeslotOffset); // [RULE10]
	wire owned = ~isMux | (slotLocal[1:0] == 2'h0); // [RULE9]
	wire [4:0] slotNum = isMux ? slotLocal[6:2] : slotLocal[4:0];
	wire byteDone = take & owned & (bitNum[2:0] == LAST_BIT);
	wire sigAllowed = (isSig | isMux) & ~commonChannelSignaling & ~signalingSourceBit;
	wire useSig = sigAllowed & (slotNum == SIG_SLOT); // [RULE5] [RULE17]
	logic [6:0] dataSh;
	logic [6:0] sigSh;
	wire [7:0] dataByte = {dataSh, dIn}; // [RULE3]
	wire [7:0] sigByte = {sigSh, sIn}; // [RULE3]

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dataSh <= '0;
			sigSh <= '0;
			txByte <= '0;
			txSlot <= '0;
			txValid <= 1'b0;
			txSigUsed <= 1'b0;
			txFrame <= '0;
		end else begin
			if (take & owned) begin
				dataSh <= dataByte[6:0]; // [RULE3]
				sigSh <= sigByte[6:0];
			end
			txValid <= byteDone;
			if (byteDone) begin
				txByte <= useSig ? sigByte : dataByte; // [RULE5]
				txSlot <= slotNum;
				txSigUsed <= useSig;
				txFrame <= frameNum;
			end
		end
	end

	// ==========
	// Shared pin and line clock outputs
	logic fsOut;
	logic pinOe;
	logic ltcOut;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fsOut <= 1'b0;
			pinOe <= 1'b0;
			ltcOut <= 1'b0;
		end else begin
			ltcOut <= lineClk;
			pinOe <= isMaster; // [RULE4] [RULE6]
			if (~isMaster)
				fsOut <= 1'b0;
			else if (fsEdge)
				fsOut <= ((take ? bitNext : bitIndex) == 10'h000); // [RULE6] [RULE8]
		end
	end
	assign link.lineTxClk = ltcOut;
	assign link.pinDevOut = fsOut;
	assign link.pinDevOe = pinOe;
endmodule

// File: hdl/etx_system_tx.sv
// System-side backplane source with an AXI4-Lite control slave
//
// Chosen here: the register offsets and register access over AXI4-Lite.
module etx_system_tx
	import etx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	etx_link_if.host link,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==========
	// Register slave
	logic [31:0] ctrl;
	logic [31:0] pattern;
	logic [15:0] fsCount;
	logic awHeld;
	logic wHeld;
	logic [3:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake = s_axi_wvalid & s_axi_wready;
	wire writeNow = awHeld & wHeld & ~s_axi_bvalid;
	wire next_awHeld = (awHeld | awTake) & ~writeNow;
	wire next_wHeld = (wHeld | wTake) & ~writeNow;
	wire wrCtrl = writeNow & (awAddr == REG_CTRL);
	wire wrPat = writeNow & (awAddr == REG_PATTERN);
	wire wrOk = wrCtrl | wrPat | (awAddr == REG_STATUS);
	wire rdHit = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_PATTERN)
		| (s_axi_araddr == REG_STATUS);
	wire [31:0] rdMux = (s_axi_araddr == REG_CTRL) ? ctrl
		: (s_axi_araddr == REG_PATTERN) ? pattern
		: (s_axi_araddr == REG_STATUS) ? {16'h0000, fsCount} : 32'h00000000;
	logic [31:0] strbMask;
	always_comb begin
		strbMask = '0;
		for (int i = 0; i < 4; i++)
			strbMask[8*i +: 8] = {8{wStrb[i]}};
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wData <= '0;
			wStrb <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			ctrl <= CTRL_RESET;
			pattern <= PATTERN_RESET;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			s_axi_awready <= ~next_awHeld & ~writeNow;
			s_axi_wready <= ~next_wHeld & ~writeNow;
			if (awTake)
				awAddr <= s_axi_awaddr;
			if (wTake) begin
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (wrCtrl)
				ctrl <= (ctrl & ~strbMask) | (wData & strbMask);
			if (wrPat)
				pattern <= (pattern & ~strbMask) | (wData & strbMask);
			if (writeNow) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else
			s_axi_arready <= 1'b1;
	end

	// ==========
	// Control decode
	wire [2:0] modeBits = ctrl[CTRL_MODE_LSB +: 3];
	wire enable = ctrl[CTRL_ENABLE];
	wire isMaster = (modeBits == MODE_MASTER);
	wire isMux = (modeBits == MODE_MUX);
	wire isSig = (modeBits == MODE_SLAVE_SIG);
	wire speed = ctrl[CTRL_SPEED] & ~isMaster;
	wire [5:0] halfLast = isMux ? (speed ? 6'(MUX_DBL_HALF - 1) : 6'(MUX_HALF - 1))
		: (speed ? 6'(BP_DBL_HALF - 1) : 6'(BP_HALF - 1));

	// ==========
	// Clock generation and line clock sampling
	logic [5:0] divCnt;
	logic genClk;
	logic [1:0] ltcSync;
	logic [1:0] pinSync;
	logic clkPrev;
	wire divWrap = (divCnt >= halfLast);
	wire clkNow = isMaster ? ltcSync[1] : genClk;
	wire launch = enable & (ctrl[CTRL_LAUNCH_RISE] ? (clkNow & ~clkPrev) : (~clkNow & clkPrev));
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			divCnt <= '0;
			genClk <= 1'b0;
			ltcSync <= '0;
			pinSync <= '0;
			clkPrev <= 1'b0;
		end else begin
			divCnt <= divWrap ? 6'h00 : divCnt + 6'h01;
			genClk <= (genClk ^ divWrap) & enable & ~isMaster;
			ltcSync <= {ltcSync[0], link.lineTxClk};
			pinSync <= {pinSync[0], link.pinLevel};
			clkPrev <= clkNow;
		end
	end

	// ==========
	// Bit sequencing
	logic phase;
	logic [9:0] hBit;
	logic [3:0] hFrame;
	logic fsPrev;
	wire [9:0] lastBit = isMux ? MUX_FRAME_BITS_LAST : FRAME_BITS_LAST;
	wire step = launch & (~speed | phase);
	// Reset start point wraps to bit 0 in every mode
	wire hWrap = (hBit >= lastBit);
	wire fsRise = pinSync[1] & ~fsPrev;
	wire [7:0] slotByte = {1'b0, hBit[9:3]} ^ pattern[7:0];
	wire [2:0] bitSel = LAST_BIT - hBit[2:0];
	wire pulseNow = (hBit == 10'h000) & (~ctrl[CTRL_MF_TYPE] | isMux | (hFrame == 4'h0));
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase <= 1'b0;
			hBit <= MUX_FRAME_BITS_LAST;
			hFrame <= MF_LAST;
			fsPrev <= 1'b0;
			fsCount <= '0;
		end else begin
			fsPrev <= pinSync[1];
			if (isMaster & fsRise)
				fsCount <= fsCount + 16'h0001;
			if (launch)
				phase <= ~phase;
			if (isMaster & launch & pinSync[1])
				hBit <= 10'h000;
			else if (step) begin
				hBit <= hWrap ? 10'h000 : hBit + 10'h001;
				if (hWrap)
					hFrame <= hFrame + 4'h1;
			end
		end
	end

	// ==========
	// Pin drivers, updated one mclk cycle after the counter
	logic bpClkO;
	logic fpO;
	logic sdO;
	logic muxClkO;
	logic muxFpO;
	logic [1:0] muxDataO;
	logic [1:0] muxSigO;
	logic pinO;
	logic pinOe;
	logic moveD;
	wire pol = ctrl[CTRL_INVERT];
	wire busSel = ctrl[CTRL_BUS];
	wire dBit = slotByte[bitSel];
	wire sBit = pattern[8 + 32'(bitSel)];
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bpClkO <= 1'b0;
			fpO <= 1'b0;
			sdO <= 1'b0;
			muxClkO <= 1'b0;
			muxFpO <= 1'b0;
			muxDataO <= '0;
			muxSigO <= '0;
			pinO <= 1'b0;
			pinOe <= 1'b0;
			moveD <= 1'b0;
		end else begin
			moveD <= launch;
			bpClkO <= genClk & ~isMux;
			muxClkO <= genClk & isMux;
			pinOe <= isSig & enable;
			fpO <= (pulseNow & ~isMux & ~isMaster) ^ pol;
			muxFpO <= (pulseNow & isMux) ^ pol;
			// Data lines move only just after a launch edge
			if (moveD) begin
				sdO <= dBit & ~isMux;
				pinO <= sBit;
				muxDataO <= busSel ? {dBit & isMux, 1'b0} : {1'b0, dBit & isMux};
				muxSigO <= busSel ? {sBit & isMux, 1'b0} : {1'b0, sBit & isMux};
			end
		end
	end
	assign link.backplaneClk = bpClkO;
	assign link.framePulse = fpO;
	assign link.serialData = sdO;
	assign link.muxClk = muxClkO;
	assign link.muxFramePulse = muxFpO;
	assign link.muxData = muxDataO;
	assign link.muxSig = muxSigO;
	assign link.pinHostOut = pinO;
	assign link.pinHostOe = pinOe;
endmodule

// File: testbench/etx_link_properties.sv
// Concurrent checks on the transmit backplane link
module etx_link_properties
	import etx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic backplaneClk,
	input wire logic framePulse,
	input wire logic serialData,
	input wire logic lineTxClk,
	input wire logic muxClk,
	input wire logic muxFramePulse,
	input wire logic [1:0] muxData,
	input wire logic [1:0] muxSig,
	input wire logic pinDevOut,
	input wire logic pinDevOe,
	input wire logic pinHostOut,
	input wire logic pinHostOe,
	input wire logic pinLevel
);
	// ==========
	// Edge and run-length helpers
	logic bpPrev, muxPrev, ltcPrev;
	logic [7:0] bpRun, muxRun, ltcRun, clkAge, syncLen;
	wire bpEdge = backplaneClk != bpPrev;
	wire muxEdge = muxClk != muxPrev;
	wire ltcEdge = lineTxClk != ltcPrev;
	wire anyEdge = bpEdge || muxEdge || ltcEdge;
	wire syncOn = pinDevOe && pinDevOut;
	function automatic logic [7:0] inc(input logic [7:0] v);
		return (v == 8'hff) ? v : v + 8'h01;
	endfunction
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{bpPrev, muxPrev, ltcPrev} <= 3'h0;
			{bpRun, muxRun, ltcRun} <= 24'hffffff;
			clkAge <= 8'h00;
			syncLen <= 8'h00;
		end else begin
			{bpPrev, muxPrev, ltcPrev} <= {backplaneClk, muxClk, lineTxClk};
			bpRun <= bpEdge ? 8'h01 : inc(bpRun);
			muxRun <= muxEdge ? 8'h01 : inc(muxRun);
			ltcRun <= ltcEdge ? 8'h01 : inc(ltcRun);
			clkAge <= anyEdge ? 8'h00 : inc(clkAge);
			syncLen <= syncOn ? inc(syncLen) : 8'h00;
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_syncStart;
		$rose(pinDevOut) && pinDevOe;
	endsequence
	sequence s_syncHeld;
		syncOn [*8];
	endsequence
	property p_oneDriver;
		!(pinDevOe && pinHostOe);
	endproperty
	property p_syncEdge;
		s_syncStart |-> ltcEdge || ltcRun <= 8'h02;
	endproperty
	property p_syncHold;
		s_syncStart |-> s_syncHeld;
	endproperty
	property p_syncLen;
		$fell(syncOn) |-> syncLen == 8'(2 * LTC_HALF);
	endproperty
	property p_ltcHalf;
		ltcEdge |-> ltcRun == 8'(LTC_HALF) || ltcRun == 8'hff;
	endproperty
	property p_bpHalf;
		bpEdge |-> bpRun inside {8'(BP_HALF), 8'(BP_DBL_HALF), 8'hff};
	endproperty
	property p_muxHalf;
		muxEdge |-> muxRun inside {8'(MUX_HALF), 8'(MUX_DBL_HALF), 8'hff};
	endproperty
	property p_launch;
		$changed(serialData) || $changed(muxData) |-> anyEdge || clkAge <= 8'h06;
	endproperty
	a_oneDriver: assert property (p_oneDriver)
		else $error("shared pin driven by both ends");
	a_syncEdge: assert property (p_syncEdge)
		else $error("frame sync not on line clock edge");
	a_syncHold: assert property (p_syncHold)
		else $error("frame sync pulse too short");
	a_syncLen: assert property (p_syncLen)
		else $error("frame sync not one bit long");
	a_ltcHalf: assert property (p_ltcHalf)
		else $error("line clock half period wrong");
	a_bpHalf: assert property (p_bpHalf)
		else $error("backplane clock half period wrong");
	a_muxHalf: assert property (p_muxHalf)
		else $error("mux clock half period wrong");
	a_launch: assert property (p_launch)
		else $error("data changed away from a clock edge");
endmodule

// File: testbench/tb.sv
// Testbench for both ends of the transmit backplane link
module tb
	import etx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	etx_mode_t mode = MODE_SLAVE_SIG;
	logic frameEdgeSelect = 1'b0, dataEdgeSelect = 1'b0, frameSyncEdgeBit = 1'b0;
	logic clockSpeedSelect = 1'b0, clockEdgeOffset = 1'b0, muxBusChoice = 1'b0;
	logic framePulseInvert = 1'b0, framePulseType = 1'b0;
	logic commonChannelSignaling = 1'b0, signalingSourceBit = 1'b0;
	logic [6:0] peerClockSpeed = 7'h00, peerClockOffset = 7'h00, timeslotOffset = 7'h00;
	logic [7:0] txByte;
	logic [4:0] txSlot;
	logic [3:0] txFrame;
	logic txValid, txSigUsed;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic b, inv;
	int bad_count = 0;
	int check_count = 0;
	int i;
	etx_link_if lnk();
	etx_framer_tx i_etx_framer_tx(.mclk, .rst, .link(lnk), .mode, .frameEdgeSelect,
		.dataEdgeSelect, .frameSyncEdgeBit, .clockSpeedSelect, .clockEdgeOffset,
		.peerClockSpeed, .peerClockOffset, .muxBusChoice, .timeslotOffset,
		.framePulseInvert, .framePulseType, .commonChannelSignaling, .signalingSourceBit,
		.txByte, .txSlot, .txValid, .txSigUsed, .txFrame);
	etx_system_tx i_etx_system_tx(.mclk, .rst, .link(lnk), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	etx_link_properties i_etx_link_properties(.mclk, .rst,
		.backplaneClk(lnk.backplaneClk), .framePulse(lnk.framePulse),
		.serialData(lnk.serialData), .lineTxClk(lnk.lineTxClk), .muxClk(lnk.muxClk),
		.muxFramePulse(lnk.muxFramePulse), .muxData(lnk.muxData), .muxSig(lnk.muxSig),
		.pinDevOut(lnk.pinDevOut), .pinDevOe(lnk.pinDevOe), .pinHostOut(lnk.pinHostOut),
		.pinHostOe(lnk.pinHostOe), .pinLevel(lnk.pinLevel));
	always #2 mclk = ~mclk;
	// ==========
	// Checking and closing
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tmo(input string nm);
		bad_count++;
		$display("[FAIL] %s expected handshake seen timeout", nm);
		report_and_stop();
	endtask
	function automatic logic [7:0] expByte(input logic [4:0] s, input logic [15:0] p,
		input logic mux, input logic sig);
		logic [6:0] ms;
		ms = mux ? timeslotOffset + {s, 2'b00} : {2'b00, s};
		return (sig && s == SIG_SLOT) ? p[15:8] : {1'b0, ms} ^ p[7:0];
	endfunction
	// ==========
	// Register bus cycles
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50) tmo("bvalid");
		chk("bresp", er, s_axi_bresp);
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 50) tmo("rvalid");
		chk("rresp", er, s_axi_rresp);
		if (er == RESP_OKAY) chk("rdata", ed, s_axi_rdata);
	endtask
	// ==========
	// One mode run: reset, program, collect 18 slots
	task automatic scen(input etx_mode_t m, input logic [7:0] ctl);
		logic [31:0] pat;
		logic [4:0] prev;
		logic sig, common_channel_signaling, src;
		int n, got;
		pat = {16'h0, 16'($urandom)};
		common_channel_signaling = 1'($urandom);
		src = 1'($urandom);
		sig = (m != MODE_MASTER) && !common_channel_signaling && !src;
		mode <= m;
		commonChannelSignaling <= common_channel_signaling;
		signalingSourceBit <= src;
		rst <= 1'b1;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		axi_wr(REG_PATTERN, pat, RESP_OKAY);
		axi_wr(REG_CTRL, {23'h0, 1'b1, ctl}, RESP_OKAY);
		got = 0;
		prev = 5'h0;
		for (n = 0; n < 40000 && got < 18; n++) begin
			@(posedge mclk);
			if (txValid === 1'b1) begin
				if (got > 0) chk("slot", 5'(prev + 5'h1), txSlot);
				chk("byte", expByte(txSlot, pat[15:0], m == MODE_MUX, sig), txByte);
				chk("sigUsed", sig && txSlot == SIG_SLOT, txSigUsed);
				chk("frame", 4'h0, txFrame);
				prev = txSlot;
				got++;
			end
		end
		if (got < 18) tmo("txValid");
		chk("devOe", m == MODE_MASTER, lnk.pinDevOe);
		chk("hostOe", m == MODE_SLAVE_SIG, lnk.pinHostOe);
	endtask
	// ==========
	// Main sequence
	initial begin
		void'($urandom(32'h62ad5c93));
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		axi_rd(REG_CTRL, CTRL_RESET, RESP_OKAY);
		axi_rd(REG_PATTERN, PATTERN_RESET, RESP_OKAY);
		axi_rd(REG_STATUS, 32'h0, RESP_OKAY);
		axi_rd(4'hc, 32'h0, RESP_SLVERR);
		axi_wr(4'hc, 32'h1, RESP_SLVERR);
		b = 1'($urandom);
		inv = 1'($urandom);
		framePulseType <= b;
		framePulseInvert <= inv;
		scen(MODE_SLAVE_SIG, {1'b0, b, inv, 1'b1, 1'b0, 3'h1});
		frameSyncEdgeBit <= 1'($urandom);
		scen(MODE_MASTER, 8'h12);
		axi_rd(REG_STATUS, {31'h0, frameSyncEdgeBit}, RESP_OKAY);
		for (i = 0; i < 2; i++) begin
			b = 1'($urandom);
			inv = 1'($urandom);
			frameEdgeSelect <= 1'b1;
			dataEdgeSelect <= 1'b1;
			muxBusChoice <= b;
			framePulseInvert <= inv;
			peerClockSpeed <= (i == 0) ? 7'h04 : 7'h00;
			timeslotOffset <= 7'($urandom_range(3));
			scen(MODE_MUX, {b, 1'b0, inv, 1'b0, i == 0, 3'h4});
		end
		report_and_stop();
	end
endmodule
